// file: hdl/host_port_pkg.sv
// Constants and types shared by the host port decoder and its register slices.
// Behaviour
// R1: Each access decodes strobe level and three address lines into one of sixteen functions.
// R2: Pattern 000 reaches the control register low byte, 001 its high byte.
// R3: Pattern 100 reaches the address pointer low byte, 101 its high byte.
// R4: Write to 010/011 stores a data byte; the pointer increments before it.
// R5: Read from 010/011 returns a data byte; the pointer increments after it.
// R6: Write to 110/111 stores a data byte and leaves the pointer alone.
// R7: Read from 110/111 returns a data byte and leaves the pointer alone.
// R8: The host reaches memory only by loading the pointer, then using data.
// R9: The host splits each 16-bit transfer into low and high byte accesses.
// R10: Auto-increment advances the pointer once per whole word, not per byte.
package host_port_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SEL_W  = 3;

  // Strobe levels on io_write_strobe_n.
  localparam logic STROBE_WRITE = 1'b0;
  localparam logic STROBE_READ  = 1'b1;

  // Address line field positions.
  localparam int unsigned SEL_BYTE_BIT  = 0;
  localparam int unsigned SEL_DATA_BIT  = 1;
  localparam int unsigned SEL_NOINC_BIT = 2;

  // Byte lane encoding of the byte select line.
  localparam logic LANE_LOW  = 1'b0;
  localparam logic LANE_HIGH = 1'b1;

  // Full address line patterns.
  localparam logic [SEL_W-1:0] SEL_CTRL_LO    = 3'h0;
  localparam logic [SEL_W-1:0] SEL_CTRL_HI    = 3'h1;
  localparam logic [SEL_W-1:0] SEL_DATA_INC_LO = 3'h2;
  localparam logic [SEL_W-1:0] SEL_DATA_INC_HI = 3'h3;
  localparam logic [SEL_W-1:0] SEL_PTR_LO     = 3'h4;
  localparam logic [SEL_W-1:0] SEL_PTR_HI     = 3'h5;
  localparam logic [SEL_W-1:0] SEL_DATA_LO    = 3'h6;
  localparam logic [SEL_W-1:0] SEL_DATA_HI    = 3'h7;

  // Reset values.
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] PTR_RESET  = 16'h0000;
  localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;

  // Pointer step per whole data word.
  localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;

  // One host I/O access as presented at the port.
  typedef struct packed {
    logic                  io_write_strobe_n;
    logic [SEL_W-1:0]      sel;
    logic [BYTE_W-1:0]     wdata;
  } host_access_t;

endpackage : host_port_pkg

// file: hdl/byte_lane_reg.sv
// A 16-bit register written either a byte at a time or as a whole word.
`timescale 1ns/1ns
`default_nettype none
module byte_lane_reg
  import host_port_pkg::*;
#(
  parameter logic [WORD_W-1:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Byte writes
  input  wire logic              wr_lo_i,
  input  wire logic              wr_hi_i,
  input  wire logic [BYTE_W-1:0] byte_i,
  // Word load, which takes priority over byte writes
  input  wire logic              load_i,
  input  wire logic [WORD_W-1:0] word_i,
  // Contents
  output logic      [WORD_W-1:0] q_o
);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RESET_VALUE;
    end else if (load_i) begin
      q_o <= word_i;
    end else begin
      if (wr_lo_i) begin
        q_o[BYTE_W-1:0] <= byte_i;
      end
      if (wr_hi_i) begin
        q_o[WORD_W-1:BYTE_W] <= byte_i;
      end
    end
  end

endmodule : byte_lane_reg
`default_nettype wire

// file: hdl/isa_io_to_host_port_decode.sv
// Decoder from host I/O accesses to byte accesses on the 16-bit host port registers.
`timescale 1ns/1ns
`default_nettype none
module isa_io_to_host_port_decode
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Host I/O access, taken on a cycle where access_valid_i is high
  input  wire logic              access_valid_i,
  input  wire host_access_t      access_i,
  // Read answer
  output logic      [BYTE_W-1:0] rdata_o,
  output logic                   rdata_valid_o,
  // Processor side
  input  wire logic              proc_data_load_i,
  input  wire logic [WORD_W-1:0] proc_data_i,
  output logic      [WORD_W-1:0] host_port_control_o,
  output logic      [WORD_W-1:0] memory_address_pointer_o,
  output logic      [WORD_W-1:0] host_port_data_o,
  output logic                   word_written_o,
  output logic                   word_read_o
);

  logic              is_write;
  logic              is_read;
  logic              hit_data;
  logic              hit_ptr;
  logic              hit_ctrl;
  logic              no_inc;
  logic              lane;
  logic              ctrl_wr_lo;
  logic              ctrl_wr_hi;
  logic              ptr_wr_lo;
  logic              ptr_wr_hi;
  logic              data_wr_lo;
  logic              data_wr_hi;
  logic              data_rd;
  logic              ptr_inc;
  logic              data_load;
  logic [WORD_W-1:0] ptr_next;
  logic [BYTE_W-1:0] rdata_d;
  logic [WORD_W-1:0] reg_sel;

  // Direction from the strobe level, register from the address lines.
  assign is_write = access_valid_i && (access_i.io_write_strobe_n == STROBE_WRITE); // R1
  assign is_read  = access_valid_i && (access_i.io_write_strobe_n == STROBE_READ);  // R1
  assign hit_data = access_i.sel[SEL_DATA_BIT];
  assign no_inc   = access_i.sel[SEL_NOINC_BIT];
  assign lane     = access_i.sel[SEL_BYTE_BIT];
  assign hit_ctrl = !hit_data && !no_inc; // R2
  assign hit_ptr  = !hit_data && no_inc;  // R3

  assign ctrl_wr_lo = is_write && hit_ctrl && (lane == LANE_LOW);  // R2
  assign ctrl_wr_hi = is_write && hit_ctrl && (lane == LANE_HIGH); // R2
  assign ptr_wr_lo  = is_write && hit_ptr && (lane == LANE_LOW);   // R3
  assign ptr_wr_hi  = is_write && hit_ptr && (lane == LANE_HIGH);  // R3
  assign data_wr_lo = is_write && hit_data && (lane == LANE_LOW);  // R4 R6
  assign data_wr_hi = is_write && hit_data && (lane == LANE_HIGH); // R4 R6
  assign data_rd    = is_read && hit_data;                         // R5 R7

  // The host sends the low byte first, so a write word is opened by its low
  // byte and a read word is closed by its high byte. Stepping there keeps a
  // pre-increment ahead of the word and a post-increment behind it.
  assign ptr_inc = hit_data && !no_inc &&
                   ((data_wr_lo) || (data_rd && lane == LANE_HIGH)); // R4 R5 R10
  assign ptr_next = memory_address_pointer_o + PTR_STEP;             // R4 R5

  // A host byte write to the data register beats a processor load.
  assign data_load = proc_data_load_i && !data_wr_lo && !data_wr_hi;

  byte_lane_reg #(
    .RESET_VALUE (CTRL_RESET)
  ) u_ctrl (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .wr_lo_i   (ctrl_wr_lo),
    .wr_hi_i   (ctrl_wr_hi),
    .byte_i    (access_i.wdata),
    .load_i    (1'b0),
    .word_i    (CTRL_RESET),
    .q_o       (host_port_control_o)
  );

  byte_lane_reg #(
    .RESET_VALUE (PTR_RESET)
  ) u_ptr (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .wr_lo_i   (ptr_wr_lo),
    .wr_hi_i   (ptr_wr_hi),
    .byte_i    (access_i.wdata),
    .load_i    (ptr_inc),
    .word_i    (ptr_next),
    .q_o       (memory_address_pointer_o)
  );

  byte_lane_reg #(
    .RESET_VALUE (DATA_RESET)
  ) u_data (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .wr_lo_i   (data_wr_lo),
    .wr_hi_i   (data_wr_hi),
    .byte_i    (access_i.wdata),
    .load_i    (data_load),
    .word_i    (proc_data_i),
    .q_o       (host_port_data_o)
  );

  // Read mux over the register that the address lines name.
  always_comb begin
    if (hit_data) begin
      reg_sel = host_port_data_o;          // R5 R7
    end else if (hit_ptr) begin
      reg_sel = memory_address_pointer_o;  // R3
    end else begin
      reg_sel = host_port_control_o;       // R2
    end
    if (lane == LANE_HIGH) begin
      rdata_d = reg_sel[WORD_W-1:BYTE_W];
    end else begin
      rdata_d = reg_sel[BYTE_W-1:0];
    end
  end

  // The read byte is captured with the access, so a post-increment in the
  // same edge cannot disturb what the host receives.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o       <= BYTE_ZERO;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= is_read; // R1
      if (is_read) begin
        rdata_o <= rdata_d;
      end
    end
  end

  // Word strobes towards the processor memory side, raised when the high
  // byte completes a word.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_written_o <= 1'b0;
      word_read_o    <= 1'b0;
    end else begin
      word_written_o <= data_wr_hi;                    // R9
      word_read_o    <= data_rd && (lane == LANE_HIGH); // R9
    end
  end

  a_rd_valid_dir: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R1
    rdata_valid_o == $past(access_valid_i && access_i.io_write_strobe_n == STROBE_READ))
    else $error("read answer not tied to a read access");

  a_wr_ctrl_hi: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R2
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel == SEL_CTRL_HI)
    |=> host_port_control_o[WORD_W-1:BYTE_W] == $past(access_i.wdata))
    else $error("control high byte not written");

  a_rd_ctrl_lo: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R2
    (access_valid_i && access_i.io_write_strobe_n == STROBE_READ
     && access_i.sel == SEL_CTRL_LO)
    |=> rdata_valid_o && rdata_o == $past(host_port_control_o[BYTE_W-1:0]))
    else $error("control low byte read wrong");

  a_rd_ptr_hi: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R3
    (access_valid_i && access_i.io_write_strobe_n == STROBE_READ
     && access_i.sel == SEL_PTR_HI)
    |=> rdata_o == $past(memory_address_pointer_o[WORD_W-1:BYTE_W]))
    else $error("pointer high byte read wrong");

  a_wr_pre_inc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R4
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel == SEL_DATA_INC_LO)
    |=> memory_address_pointer_o == $past(memory_address_pointer_o) + PTR_STEP
        && host_port_data_o[BYTE_W-1:0] == $past(access_i.wdata))
    else $error("write did not pre-increment pointer");

  a_rd_post_inc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R5
    (access_valid_i && access_i.io_write_strobe_n == STROBE_READ
     && access_i.sel == SEL_DATA_INC_HI)
    |=> memory_address_pointer_o == $past(memory_address_pointer_o) + PTR_STEP
        && rdata_o == $past(host_port_data_o[WORD_W-1:BYTE_W]))
    else $error("read did not post-increment pointer");

  a_wr_no_inc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R6
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel == SEL_DATA_HI)
    |=> $stable(memory_address_pointer_o)
        && host_port_data_o[WORD_W-1:BYTE_W] == $past(access_i.wdata))
    else $error("plain data write moved pointer");

  a_rd_no_inc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R7
    (access_valid_i && access_i.io_write_strobe_n == STROBE_READ
     && access_i.sel[SEL_DATA_BIT] && access_i.sel[SEL_NOINC_BIT])
    |=> $stable(memory_address_pointer_o))
    else $error("plain data read moved pointer");

  a_word_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R10
    ((access_valid_i && access_i.sel == SEL_DATA_INC_HI
      && access_i.io_write_strobe_n == STROBE_WRITE)
     || (access_valid_i && access_i.sel == SEL_DATA_INC_LO
      && access_i.io_write_strobe_n == STROBE_READ))
    |=> $stable(memory_address_pointer_o))
    else $error("pointer stepped on a mid-word byte");

  a_ptr_wr_lo: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R3
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel == SEL_PTR_LO)
    |=> memory_address_pointer_o[BYTE_W-1:0] == $past(access_i.wdata))
    else $error("pointer low byte not written");

  a_host_beats_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R6
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel == SEL_DATA_HI && proc_data_load_i)
    |=> host_port_data_o == {$past(access_i.wdata), $past(host_port_data_o[BYTE_W-1:0])})
    else $error("processor load overrode a host data write");

  a_word_strobe: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R9
    (access_valid_i && access_i.io_write_strobe_n == STROBE_WRITE
     && access_i.sel[SEL_DATA_BIT] && access_i.sel[SEL_BYTE_BIT])
    |=> word_written_o)
    else $error("word written strobe missing");

endmodule : isa_io_to_host_port_decode
`default_nettype wire

// file: test/isa_host_model.sv
// Behavioural host I/O driver that issues byte accesses to the decoder.
`timescale 1ns/1ns
`default_nettype none
module isa_host_model
  import host_port_pkg::*;
(
  // Clock
  input  wire logic              ref_clk_i,
  // Access lines
  output logic                   access_valid_o,
  output var host_access_t       access_o,
  // Read answer
  input  wire logic [BYTE_W-1:0] rdata_i,
  input  wire logic              rdata_valid_i
);
  initial begin
    access_valid_o = 1'b0;
    access_o       = '0;
  end
  // One byte per call; a missing answer comes back inverted so it cannot pass.
  task automatic io(input logic s, input logic [SEL_W-1:0] a, input logic [BYTE_W-1:0] w,
                    output logic [BYTE_W-1:0] rd);
    @(negedge ref_clk_i);
    access_valid_o = 1'b1;
    access_o       = '{s, a, w};
    @(negedge ref_clk_i);
    access_valid_o = 1'b0;
    // Released lines show the inverse so a stale access is never mistaken for a live one.
    access_o = ~access_o;
    rd       = rdata_valid_i ? rdata_i : ~rdata_i;
  endtask : io
  // A word always goes as low byte then high byte.
  task automatic word(input logic s, input logic [SEL_W-1:0] a, input logic [WORD_W-1:0] w,
                      output logic [WORD_W-1:0] rd);
    io(s, a, w[7:0], rd[7:0]);
    io(s, a | 3'h1, w[15:8], rd[15:8]);
  endtask : word
endmodule : isa_host_model
`default_nettype wire

// file: test/isa_io_to_host_port_decode_tb.sv
// Self-checking bench for the host I/O to host port decoder.
`timescale 1ns/1ns
`default_nettype none
module isa_io_to_host_port_decode_tb
  import host_port_pkg::*;
;
  logic               ref_clk;
  logic               nrst;
  logic               access_valid;
  host_access_t       access;
  logic [BYTE_W-1:0]  rdata;
  logic               rdata_valid;
  logic               proc_load;
  logic [WORD_W-1:0]  proc_data;
  logic [WORD_W-1:0]  ctrl;
  logic [WORD_W-1:0]  ptr;
  logic [WORD_W-1:0]  data;
  logic               word_written;
  logic               word_read;
  int                 fails = 0;
  int                 checks = 0;
  int                 cycles = 0;

  isa_host_model host (.ref_clk_i(ref_clk), .access_valid_o(access_valid), .access_o(access),
                       .rdata_i(rdata), .rdata_valid_i(rdata_valid));

  isa_io_to_host_port_decode dut (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .access_valid_i(access_valid), .access_i(access), .rdata_o(rdata),
    .rdata_valid_o(rdata_valid), .proc_data_load_i(proc_load), .proc_data_i(proc_data),
    .host_port_control_o(ctrl), .memory_address_pointer_o(ptr), .host_port_data_o(data),
    .word_written_o(word_written), .word_read_o(word_read));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // The whole run needs under fifty cycles; this ceiling only cuts a hang short.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic t_reset();
    chk(ctrl | ptr | data, 16'h0000);
    chk({5'h00, rdata_valid, word_written, word_read, rdata}, 16'h0000);
  endtask : t_reset

  task automatic t_ctrl_ptr();
    logic [WORD_W-1:0] w;
    host.word(1'b0, 3'h0, 16'h1234, w);
    chk(ctrl, 16'h1234);
    chk(ptr, 16'h0000);
    host.word(1'b0, 3'h4, 16'hFFFF, w);
    chk(ptr, 16'hFFFF);
    host.word(1'b1, 3'h0, 16'h0000, w);
    chk(w, 16'h1234);
    host.word(1'b1, 3'h4, 16'h0000, w);
    chk(w, 16'hFFFF);
  endtask : t_ctrl_ptr

  task automatic t_wr_inc();
    logic [BYTE_W-1:0] b;
    host.io(1'b0, 3'h2, 8'hA5, b);
    chk(ptr, 16'h0000);
    chk(data[7:0], 8'hA5);
    host.io(1'b0, 3'h3, 8'h5A, b);
    chk(ptr, 16'h0000);
    chk(data, 16'h5AA5);
    chk(word_written, 1'b1);
    chk(ctrl, 16'h1234);
  endtask : t_wr_inc

  task automatic t_rd_inc();
    logic [BYTE_W-1:0] b;
    host.io(1'b1, 3'h2, 8'h00, b);
    chk(b, 8'hA5);
    chk(ptr, 16'h0000);
    host.io(1'b1, 3'h3, 8'h00, b);
    chk(b, 8'h5A);
    chk(ptr, 16'h0001);
    chk(word_read, 1'b1);
  endtask : t_rd_inc

  task automatic t_no_inc();
    logic [WORD_W-1:0] w;
    @(negedge ref_clk);
    proc_load = 1'b1;
    proc_data = 16'hC3E1;
    @(negedge ref_clk);
    proc_load = 1'b0;
    chk(data, 16'hC3E1);
    host.word(1'b1, 3'h6, 16'h0000, w);
    chk(w, 16'hC3E1);
    chk(ptr, 16'h0001);
    host.word(1'b0, 3'h6, 16'h0F1E, w);
    chk(data, 16'h0F1E);
    chk(ptr, 16'h0001);
  endtask : t_no_inc

  // A host data byte and a processor load taken at one edge: the host byte must win.
  task automatic t_collide();
    logic [BYTE_W-1:0] b;
    fork
      host.io(1'b0, 3'h7, 8'h99, b);
      begin
        @(negedge ref_clk);
        proc_load = 1'b1;
        proc_data = 16'h4242;
        @(negedge ref_clk);
        proc_load = 1'b0;
      end
    join
    chk(data, 16'h991E);
    chk(ptr, 16'h0001);
  endtask : t_collide

  // Reset in mid-run clears what earlier scenarios left, and the first access after it answers.
  task automatic t_mid_reset();
    logic [BYTE_W-1:0] b;
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset();
    host.io(1'b1, 3'h1, 8'h00, b);
    chk(b, 8'h00);
  endtask : t_mid_reset

  initial begin
    nrst      = 1'b0;
    proc_load = 1'b0;
    proc_data = 16'h0000;
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset();
    t_ctrl_ptr();
    t_wr_inc();
    t_rd_inc();
    t_no_inc();
    t_collide();
    t_mid_reset();
    summarize();
  end
endmodule : isa_io_to_host_port_decode_tb
`default_nettype wire
